// >>> inc/lsrl_pkg.sv
// constants and types of the light screen reset and lockout supervisor
// How it works
// - leaving power-up lockout, latch or corrected lockout needs a manual reset
// - reset input must go open, closed, open; a stuck closure never resets
// - valid reset closure lasts 1/4 s to 2 s, then reopens
// - entering lockout turns both safety outputs off at once
// - lockout flashes status red and shows an error number on the digit
// - trip mode runs without any reset switch; only leaving a lockout waits for one
// - cycling supply for over 2 s clears a corrected lockout
// - fixed blanking ignores the taught object; moving or removing it locks out
// - each zone holding a fixed-blanked area flashes its indicator green
// - both teach switches set plus a reset teaches the blocked beams
// - alone or last in a cascade, fixed blanking may be taught remotely
// - a switch inverts the seven-segment display for upside-down mounting
// - cascades hold at most four emitter and receiver pairs
// - worst response depends on beams per screen and position in chain
// - trip turns outputs on when clear; latch needs reset after power-up and blocks
// - reset indicator steady in run, flashing in latch mode while waiting for a reset
package lsrl_pkg;
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned RST_MIN_MS = 250;
   localparam int unsigned RST_MAX_MS = 2000;
   localparam int unsigned DEBOUNCE_MS = 10;
   localparam int unsigned FLASH_MS = 250;
   localparam int unsigned RST_MIN_CYC = (RST_MIN_MS * (CLK_HZ / 1000));
   localparam int unsigned RST_MAX_CYC = (RST_MAX_MS * (CLK_HZ / 1000));
   localparam int unsigned DEBOUNCE_CYC = (DEBOUNCE_MS * (CLK_HZ / 1000));
   localparam int unsigned FLASH_CYC = (FLASH_MS * (CLK_HZ / 1000));
   localparam int unsigned MAX_PAIRS = 4;
   localparam int unsigned DEF_BEAMS = 16;
   localparam int unsigned DEF_ZONES = 4;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_CMD = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_BLANK = 8'h0c;
   localparam logic [7:0] OFS_RESP = 8'h10;
   // control fields
   localparam int unsigned CTRL_LATCH = 0;
   localparam int unsigned CTRL_TEACH_A = 1;
   localparam int unsigned CTRL_TEACH_B = 2;
   localparam int unsigned CTRL_INVERT = 3;
   localparam int unsigned CTRL_LEN_LO = 4;
   localparam int unsigned CTRL_POS_LO = 6;
   localparam logic [7:0] CTRL_RESET = 8'h01;
   localparam int unsigned CMD_TEACH = 0;
   // status fields
   localparam int unsigned STAT_STATE_LO = 0;
   localparam int unsigned STAT_OUT = 3;
   localparam int unsigned STAT_BLANK = 4;
   localparam int unsigned STAT_ARMED = 5;
   localparam int unsigned STAT_ERR_LO = 8;
   localparam int unsigned STAT_CNT_LO = 16;
   // error numbers
   localparam logic [3:0] ERR_NONE = 4'h0;
   localparam logic [3:0] ERR_BLANK_MOVED = 4'h2;
   typedef enum logic [2:0] {
      LSRL_WAIT_CLEAR,
      LSRL_WAIT_RESET,
      LSRL_RUN,
      LSRL_LOCKOUT
   } lsrl_state_t;
endpackage

// >>> logic/lsrl_reset_mon.sv
// monitored manual reset switch: debounce and closure window timing
`timescale 1ns/1ns
`default_nettype none
module lsrl_reset_mon #(
   parameter int unsigned DEB_CYC = lsrl_pkg::DEBOUNCE_CYC,
   parameter int unsigned MIN_CYC = lsrl_pkg::RST_MIN_CYC,
   parameter int unsigned MAX_CYC = lsrl_pkg::RST_MAX_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic closed_raw,
   output logic reset_pulse
);
   localparam int unsigned CW = $clog2(MAX_CYC + 2);
   localparam int unsigned DW = $clog2(DEB_CYC + 2);
   initial begin
      if (MIN_CYC < 1 || MIN_CYC > MAX_CYC || DEB_CYC < 1)
         $error("reset window parameters unusable");
   end
   logic closed_r;
   logic [DW-1:0] deb_r;
   logic [CW-1:0] hold_r;
   logic armed_r;
   logic pulse_r;
   wire logic deb_done = (deb_r == DW'(DEB_CYC));
   wire logic flip = deb_done && (closed_raw != closed_r);
   wire logic in_window = (hold_r >= CW'(MIN_CYC)) && (hold_r <= CW'(MAX_CYC));
   assign reset_pulse = pulse_r;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         deb_r <= '0;
      end else if (closed_raw == closed_r) begin
         deb_r <= '0;
      end else if (!deb_done) begin
         deb_r <= deb_r + DW'(1);
      end else begin
         deb_r <= '0;
      end
   end
   // switch assumed closed at power-up until seen open
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         closed_r <= 1'b1;
         armed_r <= 1'b0;
         hold_r <= '0;
         pulse_r <= 1'b0;
      end else begin
         pulse_r <= 1'b0;
         if (flip) begin
            closed_r <= closed_raw;
         end
         if (flip && !closed_raw) begin
            // accept only a closure inside the window
            pulse_r <= armed_r && in_window;
            armed_r <= 1'b1;
            hold_r <= '0;
         end else if (closed_r && hold_r <= CW'(MAX_CYC)) begin
            // saturates past the window, closure then void
            hold_r <= hold_r + CW'(1);
         end
      end
   end
endmodule // lsrl_reset_mon
`default_nettype wire

// >>> logic/lsrl_top.sv
// reset, lockout and blanking supervisor of a light screen receiver
`timescale 1ns/1ns
`default_nettype none
module lsrl_top #(
   parameter int unsigned BEAMS = lsrl_pkg::DEF_BEAMS,
   parameter int unsigned ZONES = lsrl_pkg::DEF_ZONES,
   parameter int unsigned DEB_CYC = lsrl_pkg::DEBOUNCE_CYC,
   parameter int unsigned MIN_CYC = lsrl_pkg::RST_MIN_CYC,
   parameter int unsigned MAX_CYC = lsrl_pkg::RST_MAX_CYC,
   parameter int unsigned FLASH_CYC = lsrl_pkg::FLASH_CYC
) (
   input wire logic CLK,
   input wire logic RST_N,
   // classic wishbone slave
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [7:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   // reset switch, high while closed
   input wire logic RESET_SW_CLOSED,
   // beam scan result
   input wire logic SCAN_VALID,
   input wire logic [BEAMS-1:0] BEAM_BLOCKED,
   input wire logic SELF_FAULT,
   input wire logic [3:0] SELF_FAULT_CODE,
   // guarded machine
   output logic SAFETY_OUTPUT_PAIR_A,
   output logic SAFETY_OUTPUT_PAIR_B,
   // indicators
   output logic STATUS_RED,
   output logic STATUS_GREEN,
   output logic RESET_YELLOW,
   output logic [ZONES-1:0] ZONE_RED,
   output logic [ZONES-1:0] ZONE_GREEN,
   output logic [6:0] DIGIT_SEG
);
   localparam int unsigned PER_ZONE = BEAMS / ZONES;
   localparam int unsigned FW = $clog2(FLASH_CYC + 1);
   localparam int unsigned NW = $clog2(BEAMS + 1);
   initial begin
      if (BEAMS < 1 || BEAMS > 32 || ZONES < 1 || (BEAMS % ZONES) != 0 || FLASH_CYC < 1)
         $error("beam or zone parameters unusable");
   end

   function automatic logic [NW-1:0] count_ones(input logic [BEAMS-1:0] v);
      logic [NW-1:0] n;
      n = '0;
      for (int i = 0; i < BEAMS; i++) begin
         n = n + NW'(v[i]);
      end
      return n;
   endfunction

   // segments g..a in bits 6..0
   function automatic logic [6:0] seg_of(input logic [3:0] d);
      logic [6:0] s;
      case (d)
         4'h0: s = 7'h3f;
         4'h1: s = 7'h06;
         4'h2: s = 7'h5b;
         4'h3: s = 7'h4f;
         4'h4: s = 7'h66;
         4'h5: s = 7'h6d;
         4'h6: s = 7'h7d;
         4'h7: s = 7'h07;
         4'h8: s = 7'h7f;
         4'h9: s = 7'h6f;
         4'ha: s = 7'h77;
         4'hb: s = 7'h7c;
         4'hc: s = 7'h39;
         4'hd: s = 7'h5e;
         4'he: s = 7'h79;
         default: s = 7'h71;
      endcase
      return s;
   endfunction

   // rotate 180 degrees: a<->d, b<->e, c<->f, g stays
   function automatic logic [6:0] seg_flip(input logic [6:0] s);
      return {s[6], s[2], s[1], s[0], s[5], s[4], s[3]};
   endfunction

   // registers
   logic [7:0] ctrl_r;
   logic teach_armed_r;
   logic [BEAMS-1:0] beams_r;
   logic [BEAMS-1:0] blank_r;
   logic blank_act_r;
   lsrl_pkg::lsrl_state_t state_r;
   lsrl_pkg::lsrl_state_t state_nxt;
   logic [3:0] err_r;
   logic [3:0] err_nxt;
   logic out_r;
   logic [FW-1:0] flash_cnt_r;
   logic flash_r;
   logic [31:0] dat_r;
   logic ack_r;
   logic st_red_r;
   logic st_grn_r;
   logic rst_led_r;
   logic [ZONES-1:0] z_red_r;
   logic [ZONES-1:0] z_grn_r;
   logic [6:0] seg_r;
   logic reset_pulse;

   lsrl_reset_mon #(
      .DEB_CYC(DEB_CYC),
      .MIN_CYC(MIN_CYC),
      .MAX_CYC(MAX_CYC)
   ) u_reset_mon (
      .clk(CLK),
      .rst_n(RST_N),
      .closed_raw(RESET_SW_CLOSED),
      .reset_pulse(reset_pulse)
   );

   // bus decode
   wire logic bus_req = WB_CYC_I && WB_STB_I && !ack_r;
   wire logic wr_ctrl = bus_req && WB_WE_I && (WB_ADR_I == lsrl_pkg::OFS_CTRL) && WB_SEL_I[0];
   wire logic wr_cmd = bus_req && WB_WE_I && (WB_ADR_I == lsrl_pkg::OFS_CMD) && WB_SEL_I[0];

   // configuration fields
   wire logic latch_mode = ctrl_r[lsrl_pkg::CTRL_LATCH];
   wire logic teach_sw = ctrl_r[lsrl_pkg::CTRL_TEACH_A] && ctrl_r[lsrl_pkg::CTRL_TEACH_B];
   wire logic invert = ctrl_r[lsrl_pkg::CTRL_INVERT];
   // two-bit fields cap the chain at four pairs
   wire logic [1:0] chain_last = ctrl_r[lsrl_pkg::CTRL_LEN_LO +: 2];
   wire logic [1:0] chain_pos = ctrl_r[lsrl_pkg::CTRL_POS_LO +: 2];
   // remote teach only alone or last in chain
   wire logic remote_ok = (chain_pos == chain_last);

   // taught object ignored; any taught beam found clear means it moved
   wire logic [BEAMS-1:0] eff_blocked = blank_act_r ? (beams_r & ~blank_r) : beams_r;
   wire logic blank_moved = blank_act_r && |(blank_r & ~beams_r);
   wire logic all_clear = !(|eff_blocked);
   wire logic fault = SELF_FAULT || blank_moved;
   wire logic teach_now = reset_pulse && (teach_sw || teach_armed_r) && !SELF_FAULT;
   wire logic [NW-1:0] n_blocked = count_ones(eff_blocked);
   // worst response in scan units grows with beams and position
   wire logic [31:0] resp_scans = 32'(BEAMS) * (32'(chain_pos) + 32'h1);

   // next state
   always_comb begin
      state_nxt = state_r;
      err_nxt = err_r;
      case (state_r)
         lsrl_pkg::LSRL_WAIT_CLEAR: begin
            // trip mode turns on once all beams clear
            if (!latch_mode && all_clear)
               state_nxt = lsrl_pkg::LSRL_RUN;
            else if (latch_mode)
               state_nxt = lsrl_pkg::LSRL_WAIT_RESET;
         end
         lsrl_pkg::LSRL_WAIT_RESET: begin
            // trip mode never waits on the switch
            if (!latch_mode)
               state_nxt = lsrl_pkg::LSRL_WAIT_CLEAR;
            // latch and power-up lockout leave on a reset
            else if (reset_pulse && all_clear && !teach_now)
               state_nxt = lsrl_pkg::LSRL_RUN;
         end
         lsrl_pkg::LSRL_RUN: begin
            // block drops outputs; latch then waits for reset
            if (!all_clear)
               state_nxt = latch_mode ? lsrl_pkg::LSRL_WAIT_RESET : lsrl_pkg::LSRL_WAIT_CLEAR;
         end
         lsrl_pkg::LSRL_LOCKOUT: begin
            // corrected lockout still needs a reset
            if (reset_pulse && !fault)
               state_nxt = lsrl_pkg::LSRL_WAIT_RESET;
         end
         default: state_nxt = lsrl_pkg::LSRL_LOCKOUT;
      endcase
      // moved object or self fault locks out from anywhere
      if (fault && !teach_now) begin
         state_nxt = lsrl_pkg::LSRL_LOCKOUT;
         if (state_r != lsrl_pkg::LSRL_LOCKOUT)
            err_nxt = SELF_FAULT ? SELF_FAULT_CODE : lsrl_pkg::ERR_BLANK_MOVED;
      end else if (state_nxt != lsrl_pkg::LSRL_LOCKOUT) begin
         err_nxt = lsrl_pkg::ERR_NONE;
      end
      // teach with a reset relearns; latch then waits for another reset, trip for all clear
      if (teach_now && state_r != lsrl_pkg::LSRL_RUN)
         state_nxt = latch_mode ? lsrl_pkg::LSRL_WAIT_RESET : lsrl_pkg::LSRL_WAIT_CLEAR;
   end

   // supply cycle: power-on reset restarts as power-up lockout
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         state_r <= lsrl_pkg::LSRL_WAIT_CLEAR;
         err_r <= lsrl_pkg::ERR_NONE;
         out_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         err_r <= err_nxt;
         // outputs off on the same edge lockout is entered
         out_r <= (state_nxt == lsrl_pkg::LSRL_RUN);
      end
   end

   // scan capture and blanking pattern
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         beams_r <= '0;
         blank_r <= '0;
         blank_act_r <= 1'b0;
      end else begin
         if (SCAN_VALID)
            beams_r <= BEAM_BLOCKED;
         // capture beams blocked at the reset
         if (teach_now && state_r != lsrl_pkg::LSRL_RUN) begin
            blank_r <= beams_r;
            blank_act_r <= |beams_r;
         end
      end
   end

   // remote teach arms the next reset; the set wins over the clear
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N)
         teach_armed_r <= 1'b0;
      else if (wr_cmd && WB_DAT_I[lsrl_pkg::CMD_TEACH] && remote_ok)
         teach_armed_r <= 1'b1;
      else if (teach_now)
         teach_armed_r <= 1'b0;
   end

   // flash timebase
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         flash_cnt_r <= '0;
         flash_r <= 1'b0;
      end else if (flash_cnt_r == FW'(FLASH_CYC - 1)) begin
         flash_cnt_r <= '0;
         flash_r <= !flash_r;
      end else begin
         flash_cnt_r <= flash_cnt_r + FW'(1);
      end
   end

   // indicators
   wire logic in_lock = (state_r == lsrl_pkg::LSRL_LOCKOUT);
   wire logic waiting = in_lock || (state_r == lsrl_pkg::LSRL_WAIT_RESET);
   wire logic [3:0] digit = in_lock ? err_r : ((n_blocked > NW'(9)) ? 4'h9 : 4'(n_blocked));
   wire logic [6:0] seg_raw = seg_of(digit);
   logic [ZONES-1:0] zone_blank;
   logic [ZONES-1:0] zone_block;
   always_comb begin
      for (int z = 0; z < ZONES; z++) begin
         zone_blank[z] = blank_act_r && |blank_r[z*PER_ZONE +: PER_ZONE];
         zone_block[z] = |eff_blocked[z*PER_ZONE +: PER_ZONE];
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         st_red_r <= 1'b1;
         st_grn_r <= 1'b0;
         rst_led_r <= 1'b0;
         z_red_r <= '0;
         z_grn_r <= '0;
         seg_r <= 7'h00;
      end else begin
         st_red_r <= in_lock ? flash_r : !out_r;
         st_grn_r <= !in_lock && out_r;
         // steady in run, flashing in latch mode while a reset is awaited
         rst_led_r <= (state_r == lsrl_pkg::LSRL_RUN) || (waiting && latch_mode && flash_r);
         z_red_r <= zone_block;
         z_grn_r <= ~zone_block & (~zone_blank | {ZONES{flash_r}});
         seg_r <= invert ? seg_flip(seg_raw) : seg_raw;
      end
   end

   // wishbone: ack one cycle after the strobe, unmapped reads zero
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         ctrl_r <= lsrl_pkg::CTRL_RESET;
         ack_r <= 1'b0;
         dat_r <= '0;
      end else begin
         ack_r <= bus_req;
         if (wr_ctrl)
            ctrl_r <= WB_DAT_I[7:0];
         if (bus_req && !WB_WE_I) begin
            case (WB_ADR_I)
               lsrl_pkg::OFS_CTRL: dat_r <= {24'h0, ctrl_r};
               lsrl_pkg::OFS_STATUS: dat_r <= {16'(n_blocked), 4'h0, err_r, 2'h0,
                  teach_armed_r, blank_act_r, out_r, 3'(state_r)};
               lsrl_pkg::OFS_BLANK: dat_r <= 32'(blank_r);
               lsrl_pkg::OFS_RESP: dat_r <= resp_scans;
               default: dat_r <= '0;
            endcase
         end
      end
   end

   assign WB_ACK_O = ack_r;
   assign WB_DAT_O = dat_r;
   assign SAFETY_OUTPUT_PAIR_A = out_r;
   assign SAFETY_OUTPUT_PAIR_B = out_r;
   assign STATUS_RED = st_red_r;
   assign STATUS_GREEN = st_grn_r;
   assign RESET_YELLOW = rst_led_r;
   assign ZONE_RED = z_red_r;
   assign ZONE_GREEN = z_grn_r;
   assign DIGIT_SEG = seg_r;
endmodule // lsrl_top
`default_nettype wire

// >>> sim/lsrl_sw_model.sv
// reset switch model: monitored closure with contact bounce, or stuck closed
`timescale 1ns/1ns
`default_nettype none
module lsrl_sw_model (
   input wire logic clk,
   input wire logic go,
   input wire logic hold,
   input wire logic [15:0] len,
   output logic closed
);
   logic [15:0] cnt_r = 16'h0000;
   logic [15:0] len_r = 16'h0000;
   always @(posedge clk) begin
      if (go && cnt_r == 16'h0000) begin
         cnt_r <= len + 16'h0002;
         len_r <= len;
      end else if (cnt_r != 16'h0000) begin
         cnt_r <= cnt_r - 16'h0001;
      end
   end
   // open, closed, open; one cycle bounce so a real debounce is needed
   assign closed = hold || (cnt_r != 16'h0000 && cnt_r != len_r + 16'h0001);
endmodule // lsrl_sw_model
`default_nettype wire

// >>> sim/lsrl_top_asserts.sv
// concurrent checks on the supervisor's ports
`timescale 1ns/1ns
`default_nettype none
module lsrl_checker #(
   parameter int unsigned BEAMS = 16
) (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [7:0] WB_ADR_I,
   input wire logic [31:0] WB_DAT_O,
   input wire logic WB_ACK_O,
   input wire logic SCAN_VALID,
   input wire logic [BEAMS-1:0] BEAM_BLOCKED,
   input wire logic SELF_FAULT,
   input wire logic SAFETY_OUTPUT_PAIR_A,
   input wire logic SAFETY_OUTPUT_PAIR_B,
   input wire logic STATUS_RED,
   input wire logic STATUS_GREEN,
   input wire logic RESET_YELLOW,
   input wire logic [6:0] DIGIT_SEG
);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_N);
   ack_one_cycle_a: assert property ((WB_CYC_I && WB_STB_I && !WB_ACK_O) |=> WB_ACK_O ##1 !WB_ACK_O)
      else $error("bus answer not a single cycle pulse");
   unmapped_zero_a: assert property ((WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_WE_I && WB_ADR_I >= 8'h14)
      |=> WB_DAT_O == 32'h0) else $error("unmapped read not zero");
   pair_agree_a: assert property (SAFETY_OUTPUT_PAIR_A == SAFETY_OUTPUT_PAIR_B)
      else $error("safety pair outputs disagree");
   fault_off_a: assert property (SELF_FAULT |-> ##[1:3] (!SAFETY_OUTPUT_PAIR_A && !SAFETY_OUTPUT_PAIR_B))
      else $error("outputs still on after fault");
   no_fault_rise_a: assert property ($rose(SAFETY_OUTPUT_PAIR_A) |-> !$past(SELF_FAULT) && !$past(SELF_FAULT, 2))
      else $error("outputs rose while fault present");
   lock_display_a: assert property (SELF_FAULT [*5] |-> DIGIT_SEG != 7'h00 && !STATUS_GREEN)
      else $error("lockout display wrong");
   scan_block_a: assert property ((SCAN_VALID && |BEAM_BLOCKED[BEAMS-1:8]) |-> ##[1:3] !SAFETY_OUTPUT_PAIR_A)
      else $error("outputs on with beam blocked");
   run_yellow_a: assert property ((SAFETY_OUTPUT_PAIR_A && $past(SAFETY_OUTPUT_PAIR_A, 2)) |-> RESET_YELLOW)
      else $error("reset indicator not steady in run");
   run_green_a: assert property ((SAFETY_OUTPUT_PAIR_A && $past(SAFETY_OUTPUT_PAIR_A, 2))
      |-> STATUS_GREEN && !STATUS_RED) else $error("status not green in run");
endmodule // lsrl_checker
bind lsrl_top lsrl_checker #(.BEAMS(BEAMS)) u_chk (.CLK(CLK), .RST_N(RST_N), .WB_CYC_I(WB_CYC_I),
   .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
   .SCAN_VALID(SCAN_VALID), .BEAM_BLOCKED(BEAM_BLOCKED), .SELF_FAULT(SELF_FAULT),
   .SAFETY_OUTPUT_PAIR_A(SAFETY_OUTPUT_PAIR_A), .SAFETY_OUTPUT_PAIR_B(SAFETY_OUTPUT_PAIR_B),
   .STATUS_RED(STATUS_RED), .STATUS_GREEN(STATUS_GREEN), .RESET_YELLOW(RESET_YELLOW), .DIGIT_SEG(DIGIT_SEG));
`default_nettype wire

// >>> sim/lsrl_top_test.sv
// self-checking bench for the reset and lockout supervisor
`timescale 1ns/1ns
`default_nettype none
module lsrl_top_test;
   localparam int unsigned FL = 4;
   typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] m; logic [31:0] e;} lsrl_row_t;
   logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, sv = 1'b0, sf = 1'b0;
   logic go = 1'b0, hold = 1'b0, ack, oa, ob, red, grn, yel, sw;
   logic [7:0] adr = 8'h00;
   logic [31:0] dati = 32'h0, dato, q;
   logic [15:0] bb = 16'h0000, len = 16'h0000;
   logic [3:0] sfc = 4'h0, zr, zg;
   logic [6:0] seg;
   logic [2:0] vor, vand;
   int miscompares = 0, n_tests = 0, cycles = 0;
   // pos 3 of last 3 arms remote teach; pos 3 of last 1 must not
   lsrl_row_t rows [12] = '{'{1'b0, 8'h00, 32'h0, 32'hff, 32'h01}, '{1'b1, 8'h00, 32'hf1, 32'h0, 32'h0},
      '{1'b0, 8'h10, 32'h0, 32'hffffffff, 32'h40}, '{1'b1, 8'h00, 32'hd1, 32'h0, 32'h0},
      '{1'b1, 8'h04, 32'h1, 32'h0, 32'h0}, '{1'b0, 8'h08, 32'h0, 32'h20, 32'h0},
      '{1'b1, 8'h00, 32'hf1, 32'h0, 32'h0}, '{1'b1, 8'h04, 32'h1, 32'h0, 32'h0},
      '{1'b0, 8'h08, 32'h0, 32'h20, 32'h20}, '{1'b0, 8'h20, 32'h0, 32'hffffffff, 32'h0},
      '{1'b1, 8'h20, 32'hffffffff, 32'h0, 32'h0}, '{1'b0, 8'h00, 32'h0, 32'hff, 32'hf1}};
   lsrl_top #(.DEB_CYC(4), .MIN_CYC(20), .MAX_CYC(100), .FLASH_CYC(FL)) uut (.CLK(clk), .RST_N(rst_n),
      .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(dati),
      .WB_DAT_O(dato), .WB_ACK_O(ack), .RESET_SW_CLOSED(sw), .SCAN_VALID(sv), .BEAM_BLOCKED(bb),
      .SELF_FAULT(sf), .SELF_FAULT_CODE(sfc), .SAFETY_OUTPUT_PAIR_A(oa), .SAFETY_OUTPUT_PAIR_B(ob),
      .STATUS_RED(red), .STATUS_GREEN(grn), .RESET_YELLOW(yel), .ZONE_RED(zr), .ZONE_GREEN(zg), .DIGIT_SEG(seg));
   lsrl_sw_model sw_m (.clk(clk), .go(go), .hold(hold), .len(len), .closed(sw));
   initial begin
      forever #5 clk = ~clk;
   end
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // run is about 1200 cycles; a hang stops well before forever
   always @(posedge clk) begin
      cycles = cycles + 1;
      if (cycles == 30000) begin
         miscompares++;
         final_report();
      end
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         $display("wrong value %s expected %h seen %h", nm, e, g);
         miscompares++;
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dati <= d;
      @(posedge clk);
      while (ack !== 1'b1 && n < 50) begin
         @(posedge clk);
         n++;
      end
      q = dato;
      chk("bus answer", 32'h1, 32'(ack));
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk(nm, e, q & m);
   endtask
   task automatic press(input logic [15:0] l);
      @(posedge clk);
      go <= 1'b1;
      len <= l;
      @(posedge clk);
      go <= 1'b0;
      repeat (l + 16) @(posedge clk);
   endtask
   task automatic scan(input logic [15:0] b);
      @(posedge clk);
      sv <= 1'b1;
      bb <= b;
      @(posedge clk);
      sv <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
   // or and and of {red, yellow, zone0 green} over two flash periods
   task automatic watch();
      vor = 3'b000;
      vand = 3'b111;
      repeat (2 * FL + 4) begin
         @(posedge clk);
         vor = vor | {red, yel, zg[0]};
         vand = vand & {red, yel, zg[0]};
      end
   endtask
   initial begin
      repeat (3) @(posedge clk);
      chk("reset outputs", 32'h080, 32'({oa, ob, red, seg}));
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      foreach (rows[i]) begin
         wb(rows[i].w, rows[i].a, rows[i].d);
         if (!rows[i].w) begin
            chk("register row", rows[i].e, q & rows[i].m);
         end
      end
      scan(16'h0003);
      press(50);
      rchk("taught pattern", 8'h0c, 32'hffff, 32'h3);
      rchk("teach status", 8'h08, 32'h38, 32'h10);
      scan(16'h0003);
      press(50);
      chk("run after teach", 32'h7, 32'({oa, ob, grn}));
      watch();
      chk("blanked zone flash", 32'h2, 32'({vor[0], vand[0]}));
      chk("steady yellow", 32'h1, 32'(vand[1]));
      scan(16'h0001);
      chk("moved object", 32'h0, 32'({oa, ob}));
      rchk("moved error", 8'h08, 32'hf0f, 32'h203);
      watch();
      chk("red flashing", 32'h2, 32'({vor[2], vand[2]}));
      chk("digit lit", 32'h1, 32'(seg != 7'h00));
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rchk("power cycle clears", 8'h08, 32'hf17, 32'h001);
      rchk("latch after power", 8'h00, 32'hff, 32'h01);
      scan(16'h0000);
      watch();
      chk("yellow waits", 32'h2, 32'({vor[1], vand[1]}));
      press(10);
      chk("short closure", 32'h0, 32'({oa, ob}));
      press(150);
      chk("long closure", 32'h0, 32'({oa, ob}));
      press(50);
      chk("valid reset", 32'h3, 32'({oa, ob}));
      scan(16'h0100);
      scan(16'h0000);
      chk("latched after block", 32'h0, 32'({oa, ob}));
      hold <= 1'b1;
      repeat (300) @(posedge clk);
      chk("stuck switch", 32'h0, 32'({oa, ob}));
      hold <= 1'b0;
      repeat (20) @(posedge clk);
      chk("stuck release", 32'h0, 32'({oa, ob}));
      press(50);
      chk("reset after block", 32'h3, 32'({oa, ob}));
      sf <= 1'b1;
      sfc <= 4'h5;
      repeat (4) @(posedge clk);
      chk("fault lockout", 32'h0, 32'({oa, ob}));
      rchk("fault error", 8'h08, 32'hf0f, 32'h503);
      press(50);
      chk("reset with fault", 32'h0, 32'({oa, ob}));
      sf <= 1'b0;
      press(50);
      rchk("corrected lockout", 8'h08, 32'h0f, 32'h01);
      press(50);
      chk("second reset runs", 32'h3, 32'({oa, ob}));
      wb(1'b1, 8'h00, 32'h0);
      scan(16'h0001);
      chk("trip blocked", 32'h0, 32'({oa, ob}));
      chk("zone lamps", 32'h1e, 32'({zr, zg}));
      // one blocked beam: segments b and c
      chk("count digit", 32'h06, 32'(seg));
      wb(1'b1, 8'h00, 32'h08);
      repeat (3) @(posedge clk);
      // upside down the same digit lights e and f
      chk("inverted digit", 32'h30, 32'(seg));
      scan(16'h0000);
      scan(16'h0000);
      chk("trip auto run", 32'h3, 32'({oa, ob}));
      final_report();
   end
endmodule // lsrl_top_test
`default_nettype wire
